// ### int_ctrl_map.svh
`ifndef INT_CTRL_MAP_SVH
`define INT_CTRL_MAP_SVH
// Summary of operation
// - bit 3 picks edge for pin 3, timer F
// - bit 2 picks edge for pin 2
// - bit 1 picks edge for pin 1, timer C
// - bit 0 picks edge for pin 0
// - enable one: 8 bits, rw, reset zero
// - enable one bit 7 gates timer A
// - enable one bit 6 reserved, rw, zero
// - enable one bit 5 gates all wakeups
// - enable one bits 4..0 gate external pins
// - enable two: 8 bits, rw, reset zero
// - enable two bit 7 gates direct transfer
// - enable two bit 6 gates converter end
// - enable two bit 5 reserved, rw, zero
// - enable two bit 4 gates timer G
// - enable two bit 3 gates timer FH
// - enable two bit 2 gates timer FL
// - enable two bit 1 gates timer C
// - enable two bit 0 gates event counter
// - flags set on event, cleared by writing 0
// - pin flag needs pin function and edge

// register offsets
`define OFS_EDGE_SEL 3'h0
`define OFS_ENABLE_ONE 3'h1
`define OFS_ENABLE_TWO 3'h2
`define OFS_REQUEST_ONE 3'h3
`define OFS_REQUEST_TWO 3'h4
`define OFS_WAKE_REQ 3'h5
// reset values
`define RST_BYTE 8'h00
`define RST_EDGE 5'h00
`define EDGE_RSV_ONES 3'h7
// enable one / request one field positions
`define BIT_TIMER_A 7
`define BIT_RSV_ONE 6
`define BIT_WAKEUP 5
`define BIT_REQ_ONE_FIXED 5
// enable two / request two field positions
`define BIT_DT 7
`define BIT_ADC 6
`define BIT_RSV_TWO 5
`define BIT_TG 4
`define BIT_TFH 3
`define BIT_TFL 2
`define BIT_TC 1
`define BIT_EC 0
// edge select positions for shared timer inputs
`define BIT_EDGE_THREE 3
`define BIT_EDGE_ONE 1
// request output vector positions
`define SRC_WAKEUP 5
`define SRC_TIMER_A 6
`define SRC_EC 7
`define SRC_TC 8
`define SRC_TFL 9
`define SRC_TFH 10
`define SRC_TG 11
`define SRC_ADC 12
`define SRC_DT 13
`define SRC_COUNT 14
`endif

// ### int_ctrl_pkg.sv
`default_nettype none
package int_ctrl_pkg;
    // sense polarity of one edge-select bit
    typedef enum logic [0:0] {
        EDGE_FALL = 1'h0,
        EDGE_RISE = 1'h1
    } edge_pol_t;
endpackage
`default_nettype wire

// ### edge_sense.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser plus edge detect, polarity per bit
module edge_sense #(
    parameter int WIDTH = 5
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] sel_i,
    output logic [WIDTH-1:0] pulse_o
);
    initial begin
        if (WIDTH < 1) begin
            $error("edge_sense: WIDTH must be at least 1");
        end
    end

    logic [WIDTH-1:0] meta_reg; // first stage, read by second only
    logic [WIDTH-1:0] sync_reg; // safe copy of the pin
    logic [WIDTH-1:0] last_reg; // previous safe copy

    // synchroniser and history, idle-high pins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_reg <= '1;
            sync_reg <= '1;
            last_reg <= '1;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // per-bit choice of rising or falling edge
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : gen_bit
            wire rise = sync_reg[g] & ~last_reg[g];
            wire fall = ~sync_reg[g] & last_reg[g];
            assign pulse_o[g] =
                (sel_i[g] == int_ctrl_pkg::EDGE_RISE) ? rise : fall;
        end
    endgenerate
endmodule
`default_nettype wire

// ### int_ctrl.sv
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_map.svh"
// edge select, enables and pending flags for the interrupt sources
module int_ctrl #(
    parameter int EXT_PINS = 5,
    parameter int WAKE_PINS = 8
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    // register port
    input wire logic [2:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // external request pins and their function select
    input wire logic [EXT_PINS-1:0] EXT_REQ_PIN_I,
    input wire logic [EXT_PINS-1:0] EXT_PIN_IS_IRQ_I,
    // timer event pins sharing edge choice
    input wire logic TIMER_F_EVENT_PIN_I,
    input wire logic TIMER_C_EVENT_PIN_I,
    output logic TIMER_F_EVENT_O,
    output logic TIMER_C_EVENT_O,
    // wakeup pins
    input wire logic [WAKE_PINS-1:0] WAKEUP_PIN_I,
    // peripheral event pulses
    input wire logic TIMER_A_OVF_I,
    input wire logic DT_DONE_I,
    input wire logic ADC_END_I,
    input wire logic TIMER_G_EVT_I,
    input wire logic TIMER_FH_EVT_I,
    input wire logic TIMER_FL_EVT_I,
    input wire logic TIMER_C_EVT_I,
    input wire logic EVENT_CNT_EVT_I,
    // requests to the processor
    output logic [`SRC_COUNT-1:0] INT_REQ_O
);
    initial begin
        if (EXT_PINS != 5) begin
            $error("int_ctrl: EXT_PINS must be 5");
        end
        if (WAKE_PINS < 1 || WAKE_PINS > 8) begin
            $error("int_ctrl: WAKE_PINS must be 1 to 8");
        end
    end

    // stored state
    logic [4:0] edge_sel_reg; // edge bits 4..0
    logic [7:0] interrupt_enable_one_reg;
    logic [7:0] interrupt_enable_two_reg;
    logic [7:0] req_one_reg; // bit 5 unused, reads one
    logic [7:0] req_two_reg;
    logic [WAKE_PINS-1:0] wake_req_reg;
    logic [7:0] rdata_reg;
    logic [`SRC_COUNT-1:0] int_req_reg;
    logic tf_evt_reg;
    logic tc_evt_reg;

    // next values
    logic [4:0] edge_sel_next;
    logic [7:0] interrupt_enable_one_next;
    logic [7:0] interrupt_enable_two_next;
    logic [7:0] req_one_next;
    logic [7:0] req_two_next;
    logic [WAKE_PINS-1:0] wake_req_next;
    logic [7:0] rdata_next;
    logic [`SRC_COUNT-1:0] int_req_next;

    // address decode
    wire wr_edge = WR_I && (ADDR_I == `OFS_EDGE_SEL);
    wire wr_en1 = WR_I && (ADDR_I == `OFS_ENABLE_ONE);
    wire wr_en2 = WR_I && (ADDR_I == `OFS_ENABLE_TWO);
    wire wr_req1 = WR_I && (ADDR_I == `OFS_REQUEST_ONE);
    wire wr_req2 = WR_I && (ADDR_I == `OFS_REQUEST_TWO);
    wire wr_wake = WR_I && (ADDR_I == `OFS_WAKE_REQ);

    // edge detectors
    logic [EXT_PINS-1:0] ext_edge;
    logic [1:0] tmr_edge;
    logic [WAKE_PINS-1:0] wake_edge;

    // shared edge choice for the two timer pins
    wire [1:0] tmr_sel = {edge_sel_reg[`BIT_EDGE_THREE],
                          edge_sel_reg[`BIT_EDGE_ONE]};

    // external pins, polarity from the edge bits
    edge_sense #(.WIDTH(EXT_PINS)) u_ext (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .pin_i(EXT_REQ_PIN_I),
        .sel_i(edge_sel_reg),
        .pulse_o(ext_edge)
    );

    // timer F and C event pins
    edge_sense #(.WIDTH(2)) u_tmr (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .pin_i({TIMER_F_EVENT_PIN_I, TIMER_C_EVENT_PIN_I}),
        .sel_i(tmr_sel),
        .pulse_o(tmr_edge)
    );

    // wakeup pins, falling edge only
    edge_sense #(.WIDTH(WAKE_PINS)) u_wake (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .pin_i(WAKEUP_PIN_I),
        .sel_i({WAKE_PINS{1'h0}}),
        .pulse_o(wake_edge)
    );

    // pin events count only where the pin is an interrupt input
    wire [4:0] ext_set = ext_edge & EXT_PIN_IS_IRQ_I;

    // set terms for request one
    wire [7:0] set_one = {TIMER_A_OVF_I, 2'h0, ext_set};

    // set terms for request two
    wire [7:0] set_two = {DT_DONE_I, ADC_END_I, 1'h0, TIMER_G_EVT_I,
                          TIMER_FH_EVT_I, TIMER_FL_EVT_I,
                          TIMER_C_EVT_I, EVENT_CNT_EVT_I};

    // bits cleared by a write of zero
    wire [7:0] clr_one = wr_req1 ? ~WDATA_I : 8'h00;
    wire [7:0] clr_two = wr_req2 ? ~WDATA_I : 8'h00;
    wire [WAKE_PINS-1:0] clr_wake =
        wr_wake ? ~WDATA_I[WAKE_PINS-1:0] : {WAKE_PINS{1'h0}};

    // write-only-clear flags; a set in the same cycle wins
    always_comb begin
        req_one_next = (req_one_reg & ~clr_one) | set_one;
        req_one_next[`BIT_REQ_ONE_FIXED] = 1'h0;
        // reserved bit 6 is plain read/write
        if (wr_req1) begin
            req_one_next[`BIT_RSV_ONE] = WDATA_I[`BIT_RSV_ONE];
        end
        req_two_next = (req_two_reg & ~clr_two) | set_two;
        // reserved bit 5 is plain read/write
        if (wr_req2) begin
            req_two_next[`BIT_RSV_TWO] = WDATA_I[`BIT_RSV_TWO];
        end
        wake_req_next = (wake_req_reg & ~clr_wake) | wake_edge;
    end

    // edge register takes the low five written bits, enable registers the whole value
    assign edge_sel_next = wr_edge ? WDATA_I[4:0] : edge_sel_reg;
    assign interrupt_enable_one_next =
        wr_en1 ? WDATA_I : interrupt_enable_one_reg;
    assign interrupt_enable_two_next =
        wr_en2 ? WDATA_I : interrupt_enable_two_reg;

    // read multiplexer, unmapped offsets read zero
    always_comb begin
        rdata_next = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                `OFS_EDGE_SEL: begin
                    rdata_next = {`EDGE_RSV_ONES, edge_sel_reg};
                end
                `OFS_ENABLE_ONE: begin
                    rdata_next = interrupt_enable_one_reg;
                end
                `OFS_ENABLE_TWO: begin
                    rdata_next = interrupt_enable_two_reg;
                end
                `OFS_REQUEST_ONE: begin
                    rdata_next = req_one_reg;
                    rdata_next[`BIT_REQ_ONE_FIXED] = 1'h1;
                end
                `OFS_REQUEST_TWO: begin
                    rdata_next = req_two_reg;
                end
                `OFS_WAKE_REQ: begin
                    rdata_next[WAKE_PINS-1:0] = wake_req_reg;
                end
                default: begin
                    rdata_next = 8'h00;
                end
            endcase
        end
    end

    // gating of pending flags by their enables
    wire [7:0] en1 = interrupt_enable_one_reg;
    wire [7:0] en2 = interrupt_enable_two_reg;
    always_comb begin
        int_req_next = '0;
        int_req_next[4:0] = req_one_reg[4:0] & en1[4:0];
        int_req_next[`SRC_WAKEUP] =
            (|wake_req_reg) & en1[`BIT_WAKEUP];
        int_req_next[`SRC_TIMER_A] =
            req_one_reg[`BIT_TIMER_A] & en1[`BIT_TIMER_A];
        int_req_next[`SRC_EC] = req_two_reg[`BIT_EC] & en2[`BIT_EC];
        int_req_next[`SRC_TC] = req_two_reg[`BIT_TC] & en2[`BIT_TC];
        int_req_next[`SRC_TFL] =
            req_two_reg[`BIT_TFL] & en2[`BIT_TFL];
        int_req_next[`SRC_TFH] =
            req_two_reg[`BIT_TFH] & en2[`BIT_TFH];
        int_req_next[`SRC_TG] = req_two_reg[`BIT_TG] & en2[`BIT_TG];
        int_req_next[`SRC_ADC] =
            req_two_reg[`BIT_ADC] & en2[`BIT_ADC];
        int_req_next[`SRC_DT] = req_two_reg[`BIT_DT] & en2[`BIT_DT];
    end

    // control registers, all cleared at reset
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            edge_sel_reg <= `RST_EDGE;
            interrupt_enable_one_reg <= `RST_BYTE;
            interrupt_enable_two_reg <= `RST_BYTE;
        end else begin
            edge_sel_reg <= edge_sel_next;
            interrupt_enable_one_reg <= interrupt_enable_one_next;
            interrupt_enable_two_reg <= interrupt_enable_two_next;
        end
    end

    // pending flags
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            req_one_reg <= `RST_BYTE;
            req_two_reg <= `RST_BYTE;
            wake_req_reg <= '0;
        end else begin
            req_one_reg <= req_one_next;
            req_two_reg <= req_two_next;
            wake_req_reg <= wake_req_next;
        end
    end

    // registered outputs
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rdata_reg <= `RST_BYTE;
            int_req_reg <= '0;
            tf_evt_reg <= 1'h0;
            tc_evt_reg <= 1'h0;
        end else begin
            rdata_reg <= rdata_next;
            int_req_reg <= int_req_next;
            tf_evt_reg <= tmr_edge[1];
            tc_evt_reg <= tmr_edge[0];
        end
    end

    assign RDATA_O = rdata_reg;
    assign INT_REQ_O = int_req_reg;
    assign TIMER_F_EVENT_O = tf_evt_reg;
    assign TIMER_C_EVENT_O = tc_evt_reg;

    // enable one write then read back
    en_one_rw_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        wr_en1 ##1 (RD_I && ADDR_I == `OFS_ENABLE_ONE && !WR_I)
        |=> RDATA_O == $past(WDATA_I, 2))
        else $error("enable one readback wrong");

    // enable two write then read back
    en_two_rw_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        wr_en2 ##1 (RD_I && ADDR_I == `OFS_ENABLE_TWO && !WR_I)
        |=> RDATA_O == $past(WDATA_I, 2))
        else $error("enable two readback wrong");

    // set beats clear on the timer A flag
    set_wins_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (TIMER_A_OVF_I && wr_req1) |=> req_one_reg[`BIT_TIMER_A])
        else $error("timer A set lost to clear");

    // flag holds with no write of zero
    flag_hold_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (req_two_reg[`BIT_ADC] && !wr_req2) |=> req_two_reg[`BIT_ADC])
        else $error("converter flag dropped");

    // pin edge ignored when pin not an interrupt input
    pin_func_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (!req_one_reg[0] && !EXT_PIN_IS_IRQ_I[0]) |=> !req_one_reg[0])
        else $error("pin 0 flag set while not irq input");

    // rising sense on pin 3 sets its flag
    edge_three_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (edge_sel_reg[3] && EXT_PIN_IS_IRQ_I[3] && u_ext.sync_reg[3]
         && !u_ext.last_reg[3]) |=> req_one_reg[3])
        else $error("pin 3 rising edge missed");

    // falling sense on pin 2 ignores rises
    edge_two_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (!edge_sel_reg[2] && u_ext.sync_reg[2] && !u_ext.last_reg[2])
        |-> !ext_edge[2])
        else $error("pin 2 rise seen in falling mode");

    // timer C pin follows edge bit 1
    edge_one_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (edge_sel_reg[1] && u_tmr.sync_reg[0] && !u_tmr.last_reg[0])
        |=> TIMER_C_EVENT_O)
        else $error("timer C rising edge missed");

    // pin 0 rising ignored in falling mode
    edge_zero_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (!edge_sel_reg[0] && !req_one_reg[0] && u_ext.sync_reg[0]
         && !u_ext.last_reg[0]) |=> !req_one_reg[0])
        else $error("pin 0 rise set flag in falling mode");

    // request follows flag and enable one cycle later
    req_gate_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        1'h1 |=> INT_REQ_O[`SRC_DT] ==
            ($past(req_two_reg[`BIT_DT]) && $past(en2[`BIT_DT])))
        else $error("direct transfer request mismatch");

    // wakeup request needs its enable
    wake_gate_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        !en1[`BIT_WAKEUP] |=> !INT_REQ_O[`SRC_WAKEUP])
        else $error("wakeup request while disabled");

    // timer A request needs its enable
    ta_gate_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        !en1[`BIT_TIMER_A] |=> !INT_REQ_O[`SRC_TIMER_A])
        else $error("timer A request while disabled");

    // timer F pin follows edge bit 3
    tf_edge_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (edge_sel_reg[`BIT_EDGE_THREE] && u_tmr.sync_reg[1]
         && !u_tmr.last_reg[1]) |=> TIMER_F_EVENT_O)
        else $error("timer F rising edge missed");

    // a write of zero clears the timer G flag
    clear_zero_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        (wr_req2 && !WDATA_I[`BIT_TG] && !TIMER_G_EVT_I)
        |=> !req_two_reg[`BIT_TG])
        else $error("timer G flag kept after clear");

    // pin 0 request needs its enable
    ext_gate_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        !en1[0] |=> !INT_REQ_O[0])
        else $error("pin 0 request while disabled");

    // timer C request needs its enable
    tc_gate_a: assert property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I)
        !en2[`BIT_TC] |=> !INT_REQ_O[`SRC_TC])
        else $error("timer C request while disabled");
endmodule
`default_nettype wire

// ### int_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// peripherals and pin drivers that stand around the controller
module int_src_model (
    input wire logic clk_i,
    output logic [7:0] evt_o, // same-clock peripheral event pulses
    output logic [4:0] ext_pin_o, // external request pins
    output logic tf_pin_o, // timer F event pin
    output logic tc_pin_o, // timer C event pin
    output logic [7:0] wake_o // wakeup pins
);
    // pins idle high so no edge is seen at start
    initial begin
        evt_o = 8'h00;
        ext_pin_o = 5'h1F;
        tf_pin_o = 1'b1;
        tc_pin_o = 1'b1;
        wake_o = 8'hFF;
    end
    // one-cycle event from peripheral idx
    task automatic pulse(input int idx);
        @(posedge clk_i);
        evt_o[idx] <= 1'b1;
        @(posedge clk_i);
        evt_o[idx] <= 1'b0;
    endtask
    // new pin levels just after an edge, then held
    task automatic pins(input logic [4:0] ext, input logic tf,
                        input logic tc, input logic [7:0] wk);
        @(posedge clk_i);
        ext_pin_o <= ext;
        tf_pin_o <= tf;
        tc_pin_o <= tc;
        wake_o <= wk;
    endtask
endmodule
`default_nettype wire

// ### interrupt_edge_and_enable_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "int_ctrl_map.svh"
// self-checking bench for edge select, enables and request flags
module interrupt_edge_and_enable_control_tb;
    logic sys_clk = 1'b0; // 10 MHz
    logic rst_b = 1'b0; // active low reset
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [4:0] is_irq = 5'h00; // pin function select
    logic [7:0] rdata;
    logic [7:0] evt;
    logic [4:0] ext_pin;
    logic tf_pin;
    logic tc_pin;
    logic [7:0] wake;
    logic tf_evt;
    logic tc_evt;
    logic [`SRC_COUNT-1:0] int_req;
    logic rd_d = 1'b0; // a read was taken at the last edge
    logic [7:0] exp_q[$]; // expected read data, oldest first
    int n_mismatch = 0;
    int num_checks = 0;
    int nf = 0; // timer F event pulses seen
    int nc = 0; // timer C event pulses seen
    // peripheral order: timer A, transfer, converter, G, FH, FL, C, counter
    int en_reg[8] = '{1, 2, 2, 2, 2, 2, 2, 2};
    int en_bit[8] = '{7, 7, 6, 4, 3, 2, 1, 0};
    int out_bit[8] = '{6, 13, 12, 11, 10, 9, 8, 7};
    // free-running system clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    int_ctrl #(.EXT_PINS(5), .WAKE_PINS(8)) i_dut (
        .SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .EXT_REQ_PIN_I(ext_pin), .EXT_PIN_IS_IRQ_I(is_irq),
        .TIMER_F_EVENT_PIN_I(tf_pin), .TIMER_C_EVENT_PIN_I(tc_pin),
        .TIMER_F_EVENT_O(tf_evt), .TIMER_C_EVENT_O(tc_evt),
        .WAKEUP_PIN_I(wake), .TIMER_A_OVF_I(evt[0]), .DT_DONE_I(evt[1]),
        .ADC_END_I(evt[2]), .TIMER_G_EVT_I(evt[3]),
        .TIMER_FH_EVT_I(evt[4]), .TIMER_FL_EVT_I(evt[5]),
        .TIMER_C_EVT_I(evt[6]), .EVENT_CNT_EVT_I(evt[7]),
        .INT_REQ_O(int_req)
    );
    int_src_model i_src (
        .clk_i(sys_clk), .evt_o(evt), .ext_pin_o(ext_pin),
        .tf_pin_o(tf_pin), .tc_pin_o(tc_pin), .wake_o(wake)
    );
    // verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // read data against its note
    task automatic cmp_data(input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value read data expected %h seen %h", e, g);
        end
    endtask
    // request lines, sampled mid-cycle
    task automatic cmp_req(input logic [`SRC_COUNT-1:0] e);
        @(negedge sys_clk);
        num_checks++;
        if (int_req !== e) begin
            n_mismatch++;
            $display("wrong value requests expected %h seen %h", e, int_req);
        end
    endtask
    // pulse counts of the timer event outputs
    task automatic cmp_cnt(input string what, input int e, input int g);
        num_checks++;
        if (g != e) begin
            n_mismatch++;
            $display("wrong value %s expected %0d seen %0d", what, e, g);
        end
    endtask
    // one write cycle
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // one read cycle, expected data noted first
    task automatic bus_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask
    // write then read back with no gap between the strobes
    task automatic bus_wr_rd(input logic [2:0] a, input logic [7:0] d,
                             input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        exp_q.push_back(e);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // answer cycle follows every taken read
    always @(posedge sys_clk) begin
        rd_d <= rd;
    end
    // oldest note against the answer
    always @(negedge sys_clk) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            cmp_data(exp_q.pop_front(), rdata);
        end
    end
    // count timer event pulses
    always @(posedge sys_clk) begin
        if (tf_evt === 1'b1) nf <= nf + 1;
        if (tc_evt === 1'b1) nc <= nc + 1;
    end
    // cut a hang short
    initial begin
        #1_000_000;
        n_mismatch++;
        end_of_test();
    end
    // main sequence
    initial begin
        logic [7:0] v;
        int j;
        int f0;
        int c0;
        void'($urandom(32'h1bb7));
        repeat (6) @(posedge sys_clk);
        rst_b <= 1'b1;
        // reset values; unmapped index reads zero
        bus_rd(3'h0, 8'hE0);
        bus_rd(3'h1, 8'h00);
        bus_rd(3'h2, 8'h00);
        bus_rd(3'h3, 8'h20);
        bus_rd(3'h4, 8'h00);
        bus_rd(3'h5, 8'h00);
        bus_rd(3'h6, 8'h00);
        // every enable bit, reserved ones too, holds what was written
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'hFF : 8'($urandom());
            bus_wr_rd(3'h1, v, v);
            bus_wr_rd(3'h2, ~v, ~v);
            bus_wr_rd(3'h0, v, {3'h7, v[4:0]});
        end
        bus_wr(3'h7, 8'hFF);
        bus_rd(3'h7, 8'h00);
        bus_wr(3'h0, 8'h00);
        bus_wr(3'h1, 8'h00);
        bus_wr(3'h2, 8'h00);
        // each peripheral flag: kept while disabled, gated by its bit
        for (int i = 0; i < 8; i++) begin
            i_src.pulse(i);
            idle(2);
            cmp_req('0);
            bus_rd(3'(en_reg[i] + 2),
                   (i == 0 ? 8'h20 : 8'h00) | (8'h01 << en_bit[i]));
            bus_wr(3'(en_reg[i]), 8'h01 << en_bit[i]);
            idle(1);
            cmp_req(14'h0001 << out_bit[i]);
            bus_wr(3'(en_reg[i] + 2), 8'hFF);
            idle(1);
            cmp_req(14'h0001 << out_bit[i]);
            bus_wr(3'(en_reg[i] + 2), 8'h00);
            idle(1);
            cmp_req('0);
            bus_wr(3'(en_reg[i]), 8'h00);
        end
        // timer A event and a clearing write in one cycle: set wins
        fork
            i_src.pulse(0);
            bus_wr(3'h3, 8'h00);
        join
        bus_rd(3'h3, 8'hA0);
        bus_wr(3'h3, 8'h00);
        // pin flags on the chosen edge only
        is_irq <= 5'h1F;
        for (int n = 0; n < 5; n++) begin
            for (int p = 0; p < 2; p++) begin
                bus_wr(3'h0, 8'(p) << n);
                bus_wr(3'h1, 8'h01 << n);
                for (int s = 0; s < 2; s++) begin
                    i_src.pins(s ? 5'h1F : ~(5'h01 << n), 1'b1, 1'b1, 8'hFF);
                    idle(4);
                    cmp_req(p == s ? 14'h0001 << n : '0);
                    bus_wr(3'h3, 8'h00);
                    idle(1);
                end
            end
        end
        // no pin flag while the pin serves another function
        is_irq <= 5'h00;
        bus_wr(3'h0, 8'h00);
        i_src.pins(5'h00, 1'b1, 1'b1, 8'hFF);
        idle(4);
        cmp_req('0);
        bus_rd(3'h3, 8'h20);
        i_src.pins(5'h1F, 1'b1, 1'b1, 8'hFF);
        bus_wr(3'h1, 8'h00);
        // shared edge bits steer the timer event pins too
        for (int p = 0; p < 2; p++) begin
            bus_wr(3'h0, p ? 8'h08 : 8'h02);
            f0 = nf;
            c0 = nc;
            i_src.pins(5'h1F, 1'b0, 1'b0, 8'hFF);
            idle(5);
            cmp_cnt("timer F events", 1 - p, nf - f0);
            cmp_cnt("timer C events", p, nc - c0);
            i_src.pins(5'h1F, 1'b1, 1'b1, 8'hFF);
            idle(5);
            cmp_cnt("timer F events", 1, nf - f0);
            cmp_cnt("timer C events", 1, nc - c0);
        end
        // any wakeup pin falling edge, one shared enable
        bus_wr(3'h1, 8'h20);
        j = $urandom_range(7);
        i_src.pins(5'h1F, 1'b1, 1'b1, ~(8'h01 << j));
        idle(4);
        cmp_req(14'h0001 << `SRC_WAKEUP);
        bus_rd(3'h5, 8'h01 << j);
        bus_wr(3'h5, 8'h00);
        idle(1);
        cmp_req('0);
        i_src.pins(5'h1F, 1'b1, 1'b1, 8'hFF);
        // a second reset clears the enables again
        bus_wr(3'h2, 8'hFF);
        rst_b <= 1'b0;
        idle(2);
        rst_b <= 1'b1;
        bus_rd(3'h2, 8'h00);
        bus_rd(3'h1, 8'h00);
        idle(2);
        end_of_test();
    end
endmodule
`default_nettype wire
